// [verilog/crc_core.sv]
`timescale 1ns/10ps
module crc_core
  import crc_pkg::*;
(
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RESETN,
  // Sequencer request
  input  wire logic        OP_VALID,
  input  wire crc_op_t     OP_CODE,
  input  wire logic [7:0]  MEM_DATA,
  input  wire logic [2:0]  BIT_SEL,
  input  wire logic        INSN_DONE,
  // Indexed addressing
  input  wire crc_ofs_t    OFS_LEN,
  input  wire logic [15:0] OFS_VAL,
  // Interrupt sequence
  input  wire logic        IRQ_N,
  input  wire logic        STACKED,
  input  wire logic        RET_VALID,
  input  wire logic [7:0]  RET_CCR,
  input  wire logic [7:0]  RET_ACC,
  input  wire logic [7:0]  RET_IDX,
  // Outputs
  output logic             CPU_CE,
  output logic [7:0]       ACC,
  output logic [7:0]       IDX,
  output logic [7:0]       CONDITION_CODE_REGISTER,
  output logic [7:0]       STORE_DATA,
  output logic [15:0]      EFF_ADDR,
  output logic             IRQ_PENDING,
  output logic             INT_START
);

  // ****************************************************
  // Processor cycle enable
  // ****************************************************
  logic div_ff;

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      div_ff <= 1'b0;
      CPU_CE <= 1'b0;
    end else begin
      div_ff <= ~div_ff;
      CPU_CE <= div_ff;
    end
  end

  // ****************************************************
  // Arithmetic unit
  // ****************************************************
  logic [7:0] res;
  logic       c_out;
  logic       h_out;
  logic       wr_a;
  logic       wr_x;
  logic       upd_nz;
  logic       upd_c;
  logic       upd_h;
  logic       step;

  assign step = OP_VALID && CPU_CE;

  crc_alu u_alu (
    .op      (OP_CODE),
    .a_in    (ACC),
    .x_in    (IDX),
    .m_in    (MEM_DATA),
    .c_in    (CONDITION_CODE_REGISTER[CC_C]),
    .bit_sel (BIT_SEL),
    .res     (res),
    .c_out   (c_out),
    .h_out   (h_out),
    .wr_a    (wr_a),
    .wr_x    (wr_x),
    .upd_nz  (upd_nz),
    .upd_c   (upd_c),
    .upd_h   (upd_h)
  );

  // ****************************************************
  // Accumulator and index register
  // ****************************************************
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      ACC <= ACC_RESET;
    end else if (CPU_CE && RET_VALID) begin
      ACC <= RET_ACC;
    end else if (step && wr_a) begin
      ACC <= res;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      IDX <= IDX_RESET;
    end else if (CPU_CE && RET_VALID) begin
      IDX <= RET_IDX;
    end else if (step && wr_x) begin
      IDX <= res;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      STORE_DATA <= 8'h00;
    end else if (step && (OP_CODE == OP_STA)) begin
      STORE_DATA <= ACC;
    end else if (step && (OP_CODE == OP_STX)) begin
      STORE_DATA <= IDX;
    end
  end

  // ****************************************************
  // Effective address
  // ****************************************************
  logic [15:0] nxt_ea;

  always_comb begin
    case (OFS_LEN)
      OFS_NONE: nxt_ea = {8'h00, IDX};
      OFS_ONE:  nxt_ea = {8'h00, IDX} + {8'h00, OFS_VAL[7:0]};
      OFS_TWO:  nxt_ea = {8'h00, IDX} + OFS_VAL;
      default:  nxt_ea = {8'h00, IDX};
    endcase
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      EFF_ADDR <= 16'h0000;
    end else begin
      EFF_ADDR <= nxt_ea;
    end
  end

  // ****************************************************
  // Condition codes
  // ****************************************************
  logic [7:0] cc;
  logic [7:0] nxt_cc;
  logic       take_int;

  assign cc = CONDITION_CODE_REGISTER;

  always_comb begin
    nxt_cc = cc | CC_UNUSED;
    if (CPU_CE && RET_VALID) begin
      nxt_cc = RET_CCR | CC_UNUSED;
    end else if (CPU_CE && STACKED) begin
      nxt_cc[CC_I] = 1'b1;
    end else if (step) begin
      if (upd_h) nxt_cc[CC_H] = h_out;
      if (upd_nz) begin
        nxt_cc[CC_N] = res[7];
        nxt_cc[CC_Z] = (res == 8'h00);
      end
      if (upd_c) nxt_cc[CC_C] = c_out;
      if (OP_CODE == OP_SEI) nxt_cc[CC_I] = 1'b1;
      if (OP_CODE == OP_CLI) nxt_cc[CC_I] = 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      CONDITION_CODE_REGISTER <= CC_RESET;
    end else begin
      CONDITION_CODE_REGISTER <= nxt_cc;
    end
  end

  // ****************************************************
  // External interrupt latch
  // ****************************************************
  // Request is synchronised; falling edge sets a latch that only entry or reset clears,
  // so a request during mask waits instead of being lost.
  logic irq_s1_ff;
  logic irq_s2_ff;
  logic irq_d_ff;

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      irq_s1_ff <= 1'b1;
      irq_s2_ff <= 1'b1;
      irq_d_ff  <= 1'b1;
    end else begin
      irq_s1_ff <= IRQ_N;
      irq_s2_ff <= irq_s1_ff;
      irq_d_ff  <= irq_s2_ff;
    end
  end

  assign take_int = CPU_CE && INSN_DONE && IRQ_PENDING && !cc[CC_I];

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      IRQ_PENDING <= 1'b0;
    end else if (irq_d_ff && !irq_s2_ff) begin
      IRQ_PENDING <= 1'b1;
    end else if (take_int) begin
      IRQ_PENDING <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      INT_START <= 1'b0;
    end else begin
      INT_START <= take_int;
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);

  sequence s_add_step;
    step && upd_h;
  endsequence

  a_ce_alternates: assert property (CPU_CE |=> !CPU_CE ##1 CPU_CE)
    else $error("cycle enable not every second clock");
  a_acc_load: assert property (step && OP_CODE == OP_LDA && !RET_VALID
    |=> ACC == $past(MEM_DATA))
    else $error("accumulator load wrong");
  a_idx_load: assert property (step && OP_CODE == OP_LDX && !RET_VALID
    |=> IDX == $past(MEM_DATA))
    else $error("index load wrong");
  a_ea_sum: assert property (OFS_LEN == OFS_ONE
    |=> EFF_ADDR == {8'h00, $past(IDX)} + {8'h00, $past(OFS_VAL[7:0])})
    else $error("effective address wrong");
  // Nibble sum is kept five bits wide so the carry into bit 4 is visible
  a_half_carry: assert property ((s_add_step and (!RET_VALID && !STACKED))
    |=> cc[CC_H] == (({1'b0, $past(ACC[3:0])} + {1'b0, $past(MEM_DATA[3:0])}
        + ($past(OP_CODE) == OP_ADC ? {4'h0, $past(cc[CC_C])} : 5'h00)) > 5'h0f))
    else $error("half carry wrong");
  a_h_held: assert property (!(step && upd_h) && !RET_VALID |=> $stable(cc[CC_H]))
    else $error("half carry changed");
  a_mask_blocks: assert property (cc[CC_I] |=> !INT_START)
    else $error("interrupt taken while masked");
  a_stack_mask: assert property (CPU_CE && STACKED && !RET_VALID |=> cc[CC_I])
    else $error("mask not set on entry");
  a_pending_held: assert property (IRQ_PENDING && !take_int |=> IRQ_PENDING)
    else $error("pending request lost");
  a_return_cc: assert property (CPU_CE && RET_VALID
    |=> cc == ($past(RET_CCR) | CC_UNUSED))
    else $error("condition codes not restored");
  a_mask_clear_sw: assert property ($fell(cc[CC_I])
    |-> $past(step && OP_CODE == OP_CLI || CPU_CE && RET_VALID))
    else $error("mask cleared by hardware");
  a_zero_flag: assert property (step && upd_nz && !RET_VALID && !STACKED
    |=> cc[CC_Z] == ($past(res) == 8'h00) && cc[CC_N] == $past(res[7]))
    else $error("zero or negative flag wrong");
  a_rotate_carry: assert property (step && OP_CODE == OP_ROL
    && !RET_VALID && !STACKED
    |=> cc[CC_C] == $past(ACC[7]) && ACC[0] == $past(cc[CC_C]))
    else $error("rotate through carry wrong");
  a_int_at_end: assert property (INT_START |-> $past(INSN_DONE && CPU_CE))
    else $error("interrupt started mid instruction");
  a_add_keeps_mask: assert property (step && OP_CODE == OP_ADD
    && !RET_VALID && !STACKED
    |=> $stable(cc[CC_I]))
    else $error("add changed mask");

endmodule

// [verilog/crc_pkg.sv]
package crc_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;

  // Condition code bit positions; bits 7..5 read as one
  localparam int CC_C = 0;
  localparam int CC_Z = 1;
  localparam int CC_N = 2;
  localparam int CC_I = 3;
  localparam int CC_H = 4;

  localparam logic [7:0] CC_RESET  = 8'hf8;
  localparam logic [7:0] CC_UNUSED = 8'he0;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] IDX_RESET = 8'h00;
  localparam int         CLK_DIV   = 2;

  // Operation codes driven by the instruction sequencer
  typedef enum logic [4:0] {
    OP_NOP  = 5'h00,
    OP_LDA  = 5'h01,
    OP_LDX  = 5'h02,
    OP_STA  = 5'h03,
    OP_STX  = 5'h04,
    OP_ADD  = 5'h05,
    OP_ADC  = 5'h06,
    OP_SUB  = 5'h07,
    OP_SBC  = 5'h08,
    OP_CMP  = 5'h09,
    OP_CPX  = 5'h0a,
    OP_AND  = 5'h0b,
    OP_ORA  = 5'h0c,
    OP_EOR  = 5'h0d,
    OP_LSL  = 5'h0e,
    OP_LSR  = 5'h0f,
    OP_ROL  = 5'h10,
    OP_ROR  = 5'h11,
    OP_ASR  = 5'h12,
    OP_SEI  = 5'h13,
    OP_CLI  = 5'h14,
    OP_BTST = 5'h15,
    OP_TAX  = 5'h16,
    OP_TXA  = 5'h17,
    OP_INCX = 5'h18,
    OP_DECX = 5'h19
  } crc_op_t;

  // Index offset length select
  typedef enum logic [1:0] {
    OFS_NONE = 2'h0,
    OFS_ONE  = 2'h1,
    OFS_TWO  = 2'h2
  } crc_ofs_t;

endpackage

// [verilog/crc_alu.sv]
`timescale 1ns/10ps
module crc_alu
  import crc_pkg::*;
(
  // Operation
  input  wire crc_op_t    op,
  input  wire logic [7:0] a_in,
  input  wire logic [7:0] x_in,
  input  wire logic [7:0] m_in,
  input  wire logic       c_in,
  input  wire logic [2:0] bit_sel,
  // Results
  output logic [7:0] res,
  output logic       c_out,
  output logic       h_out,
  output logic       wr_a,
  output logic       wr_x,
  output logic       upd_nz,
  output logic       upd_c,
  output logic       upd_h
);

  logic [8:0] sum;
  logic [4:0] low;
  logic [7:0] opnd;

  always_comb begin
    sum    = 9'h000;
    low    = 5'h00;
    opnd   = 8'h00;
    res    = a_in;
    c_out  = c_in;
    h_out  = 1'b0;
    wr_a   = 1'b0;
    wr_x   = 1'b0;
    upd_nz = 1'b0;
    upd_c  = 1'b0;
    upd_h  = 1'b0;
    case (op)
      OP_LDA: begin
        res = m_in; wr_a = 1'b1; upd_nz = 1'b1;
      end
      OP_LDX: begin
        res = m_in; wr_x = 1'b1; upd_nz = 1'b1;
      end
      OP_STA: begin
        res = a_in; upd_nz = 1'b1;
      end
      OP_STX: begin
        res = x_in; upd_nz = 1'b1;
      end
      OP_ADD, OP_ADC: begin
        opnd  = (op == OP_ADC) ? {7'h00, c_in} : 8'h00;
        sum   = {1'b0, a_in} + {1'b0, m_in} + {1'b0, opnd};
        low   = {1'b0, a_in[3:0]} + {1'b0, m_in[3:0]} + {4'h0, opnd[0]};
        res   = sum[7:0];
        c_out = sum[8];
        h_out = low[4];
        wr_a = 1'b1; upd_nz = 1'b1; upd_c = 1'b1; upd_h = 1'b1;
      end
      OP_SUB, OP_SBC, OP_CMP, OP_CPX: begin
        opnd  = (op == OP_SBC) ? {7'h00, c_in} : 8'h00;
        sum   = {1'b0, (op == OP_CPX) ? x_in : a_in} - {1'b0, m_in} - {1'b0, opnd};
        res   = sum[7:0];
        c_out = sum[8];
        wr_a  = (op == OP_SUB) || (op == OP_SBC);
        upd_nz = 1'b1; upd_c = 1'b1;
      end
      OP_AND: begin res = a_in & m_in; wr_a = 1'b1; upd_nz = 1'b1; end
      OP_ORA: begin res = a_in | m_in; wr_a = 1'b1; upd_nz = 1'b1; end
      OP_EOR: begin res = a_in ^ m_in; wr_a = 1'b1; upd_nz = 1'b1; end
      OP_LSL, OP_ROL: begin
        res   = {a_in[6:0], (op == OP_ROL) ? c_in : 1'b0};
        c_out = a_in[7];
        wr_a = 1'b1; upd_nz = 1'b1; upd_c = 1'b1;
      end
      OP_LSR, OP_ROR, OP_ASR: begin
        res   = {(op == OP_ROR) ? c_in : ((op == OP_ASR) ? a_in[7] : 1'b0), a_in[7:1]};
        c_out = a_in[0];
        wr_a = 1'b1; upd_nz = 1'b1; upd_c = 1'b1;
      end
      OP_BTST: begin
        c_out = m_in[bit_sel];
        upd_c = 1'b1;
      end
      OP_TAX: begin res = a_in; wr_x = 1'b1; end
      OP_TXA: begin res = x_in; wr_a = 1'b1; end
      OP_INCX: begin
        res = x_in + 8'h01; wr_x = 1'b1; upd_nz = 1'b1;
      end
      OP_DECX: begin
        res = x_in - 8'h01; wr_x = 1'b1; upd_nz = 1'b1;
      end
      default: begin
        res = a_in;
      end
    endcase
  end

endmodule

// [tb/crc_partner.sv]
`timescale 1ns/10ps
module crc_partner
  import crc_pkg::*;
(
  // Core side
  input  wire logic       clock,
  input  wire logic       cpu_ce,
  input  wire logic       int_start,
  input  wire logic       ret_req,
  input  wire logic [7:0] condition_code_register,
  input  wire logic [7:0] acc,
  input  wire logic [7:0] idx,
  // Sequencer answers
  output logic            stacked,
  output logic            ret_valid,
  output logic [7:0]      ret_ccr,
  output logic [7:0]      ret_acc,
  output logic [7:0]      ret_idx
);
  // ****************************************
  // Stacking and return sequence
  // ****************************************
  task automatic wait_ce();
    for (int k = 0; k < 4 && cpu_ce !== 1'b1; k++) @(negedge clock);
  endtask

  initial begin
    stacked = 1'b0;
    ret_valid = 1'b0;
    ret_ccr = 8'h00;
    ret_acc = 8'h00;
    ret_idx = 8'h00;
    forever begin
      @(negedge clock);
      if (int_start === 1'b1) begin
        // Push happens before the mask is raised
        ret_ccr = condition_code_register;
        ret_acc = acc;
        ret_idx = idx;
        wait_ce();
        stacked = 1'b1;
        @(negedge clock);
        stacked = 1'b0;
      end else if (ret_req === 1'b1) begin
        wait_ce();
        ret_valid = 1'b1;
        @(negedge clock);
        ret_valid = 1'b0;
        // Pulled bytes no longer stand on the bus
        ret_ccr = ~ret_ccr;
        ret_acc = ~ret_acc;
        ret_idx = ~ret_idx;
      end
    end
  end
endmodule

// [tb/tb_top.sv]
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  import crc_pkg::*;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic        clock, rst_n, op_valid, insn_done, irq_n, ret_req;
  crc_op_t     op_code;
  crc_ofs_t    ofs_len;
  logic [7:0]  mem_data, acc, idx, condition_code_register, store_data, ret_ccr, ret_acc, ret_idx;
  logic [2:0]  bit_sel;
  logic [15:0] ofs_val, eff_addr;
  logic        cpu_ce, irq_pending, int_start, stacked, ret_valid;
  int          bad_count, cmp_count, int_seen;

  crc_core i_crc_core (.CLOCK(clock), .RESETN(rst_n), .OP_VALID(op_valid),
    .OP_CODE(op_code), .MEM_DATA(mem_data), .BIT_SEL(bit_sel), .INSN_DONE(insn_done),
    .OFS_LEN(ofs_len), .OFS_VAL(ofs_val), .IRQ_N(irq_n), .STACKED(stacked),
    .RET_VALID(ret_valid), .RET_CCR(ret_ccr), .RET_ACC(ret_acc), .RET_IDX(ret_idx),
    .CPU_CE(cpu_ce), .ACC(acc), .IDX(idx), .CONDITION_CODE_REGISTER(condition_code_register),
    .STORE_DATA(store_data), .EFF_ADDR(eff_addr), .IRQ_PENDING(irq_pending),
    .INT_START(int_start));

  crc_partner i_crc_partner (.clock(clock), .cpu_ce(cpu_ce), .int_start(int_start),
    .ret_req(ret_req), .condition_code_register(condition_code_register), .acc(acc), .idx(idx), .stacked(stacked),
    .ret_valid(ret_valid), .ret_ccr(ret_ccr), .ret_acc(ret_acc), .ret_idx(ret_idx));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  always @(negedge clock) if (int_start === 1'b1) int_seen++;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic end_sim();
    $display("mismatches %0d compares %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic give_up();
    bad_count++;
    end_sim();
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask

  // Request is held across the enabled edge, results land before the next fall
  task automatic op(input crc_op_t c, input logic [7:0] m);
    int k;
    for (k = 0; k < 8 && cpu_ce !== 1'b1; k++) tick(1);
    if (k == 8) give_up();
    op_valid = 1'b1;
    op_code = c;
    mem_data = m;
    tick(1);
    op_valid = 1'b0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    `CHK(condition_code_register, 8'hf8)
    `CHK(acc, 8'h00)
    `CHK(idx, 8'h00)
  endtask

  task automatic t_clock();
    logic p;
    for (int k = 0; k < 4; k++) begin
      p = cpu_ce;
      tick(1);
      `CHK(cpu_ce, ~p)
    end
  endtask

  task automatic t_arith();
    op(OP_LDA, 8'h8f);
    `CHK(acc, 8'h8f)
    `CHK(condition_code_register, 8'hfc)
    op(OP_ADD, 8'h81);
    `CHK(acc, 8'h10)
    `CHK(condition_code_register, 8'hf9)
    op(OP_SUB, 8'h20);
    `CHK(acc, 8'hf0)
    `CHK(condition_code_register, 8'hfd)
    op(OP_LDA, 8'h00);
    `CHK(condition_code_register, 8'hfb)
  endtask

  task automatic t_shift();
    op(OP_LDA, 8'h81);
    op(OP_LSL, 8'h00);
    `CHK({acc, condition_code_register}, 16'h02f9)
    op(OP_ROL, 8'h00);
    `CHK({acc, condition_code_register}, 16'h05f8)
    op(OP_ROR, 8'h00);
    `CHK({acc, condition_code_register}, 16'h02f9)
    op(OP_STA, 8'h00);
    `CHK(store_data, 8'h02)
    bit_sel = 3'h2;
    op(OP_BTST, 8'h08);
    `CHK(condition_code_register, 8'hf8)
    bit_sel = 3'h3;
    op(OP_BTST, 8'h08);
    `CHK(condition_code_register, 8'hf9)
  endtask

  task automatic t_index();
    op(OP_LDX, 8'h10);
    `CHK(idx, 8'h10)
    op(OP_CPX, 8'h10);
    `CHK(condition_code_register, 8'hfa)
    ofs_len = OFS_TWO;
    ofs_val = 16'h1234;
    tick(2);
    `CHK(eff_addr, 16'h1244)
    ofs_len = OFS_ONE;
    ofs_val = 16'h12f0;
    tick(2);
    `CHK(eff_addr, 16'h0100)
    ofs_len = OFS_NONE;
    tick(2);
    `CHK(eff_addr, 16'h0010)
  endtask

  task automatic t_irq();
    int k;
    irq_n = 1'b0;
    tick(2);
    irq_n = 1'b1;
    tick(6);
    `CHK(irq_pending, 1'b1)
    `CHK(int_seen, 0)
    // Hold off completion so the latch must wait past the unmask
    insn_done = 1'b0;
    op(OP_CLI, 8'h00);
    `CHK(condition_code_register, 8'hf2)
    tick(8);
    `CHK(int_seen, 0)
    insn_done = 1'b1;
    for (k = 0; k < 8 && int_seen == 0; k++) tick(1);
    if (k == 8) give_up();
    `CHK(int_seen, 1)
    `CHK(irq_pending, 1'b0)
    for (k = 0; k < 8 && condition_code_register[CC_I] !== 1'b1; k++) tick(1);
    if (k == 8) give_up();
    `CHK(condition_code_register[CC_I], 1'b1)
    op(OP_LDA, 8'h55);
    ret_req <= 1'b1;
    tick(1);
    ret_req <= 1'b0;
    tick(6);
    `CHK(condition_code_register, 8'hf2)
    `CHK({acc, idx}, 16'h0210)
  endtask

  // Covers the remaining operation codes except OP_NOP, carry-in forms after ADD and CMP
  task automatic t_logic();
    op(OP_LDA, 8'h0f);
    op(OP_ADD, 8'h00);
    `CHK(condition_code_register, 8'he0)
    op(OP_CMP, 8'h10);
    `CHK({acc, condition_code_register}, 16'h0fe5)
    op(OP_ADC, 8'h00);
    `CHK({acc, condition_code_register}, 16'h10f0)
    op(OP_SBC, 8'h11);
    `CHK({acc, condition_code_register}, 16'hfff5)
    op(OP_AND, 8'h3c);
    op(OP_ORA, 8'h81);
    `CHK({acc, condition_code_register}, 16'hbdf5)
    op(OP_EOR, 8'hbd);
    `CHK({acc, condition_code_register}, 16'h00f3)
    op(OP_LDA, 8'h81);
    op(OP_ASR, 8'h00);
    `CHK({acc, condition_code_register}, 16'hc0f5)
    op(OP_LSR, 8'h00);
    `CHK({acc, condition_code_register}, 16'h60f0)
    op(OP_TAX, 8'h00);
    op(OP_STX, 8'h00);
    `CHK(store_data, 8'h60)
    op(OP_LDX, 8'h00);
    op(OP_DECX, 8'h00);
    `CHK({idx, condition_code_register}, 16'hfff4)
    op(OP_TXA, 8'h00);
    op(OP_INCX, 8'h00);
    `CHK({acc, idx, condition_code_register}, 24'hff00f2)
    op(OP_SEI, 8'h00);
    `CHK(condition_code_register, 8'hfa)
  endtask

  task automatic t_reset2();
    rst_n = 1'b0;
    tick(1);
    `CHK(condition_code_register, 8'hf8)
    `CHK(irq_pending, 1'b0)
    rst_n = 1'b1;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    op_valid = 1'b0;
    op_code = OP_NOP;
    mem_data = 8'h00;
    bit_sel = 3'h0;
    insn_done = 1'b1;
    ofs_len = OFS_NONE;
    ofs_val = 16'h0000;
    irq_n = 1'b1;
    ret_req = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    int_seen = 0;
    tick(2);
    t_reset();
    rst_n = 1'b1;
    tick(2);
    t_clock();
    t_arith();
    t_shift();
    t_index();
    t_irq();
    t_logic();
    t_reset2();
    tick(4);
    end_sim();
  end
endmodule
